// ### core/escape_lane_tx.sv
// Operation
// (R01) Force-stop high puts lane in Stop immediately
// (R02) One clock period per low-power phase
// (R03) Escape entry needs request plus exactly one select
// (R04) Escape mode held while request stays high
// (R05) Protocol raises escape only with high-speed low
// (R06) High-speed request wins over escape request
// (R07) Data select enters low-power data transmission
// (R08) Data select excludes ultra-low and triggers
// (R09) Ultra-low select enters ultra-low-power state
// (R10) Ultra-low select excludes data and triggers
// (R11) Exit request drives Mark-1, Stop after release
// (R12) Exit request ignored outside ultra-low-power
// (R13) Trigger sent, Stop when request drops
// (R14) Protocol asserts one trigger, no other select
// (R15) Map reset, unknown-3, unknown-5 trigger patterns
// (R16) Escape byte sent bit zero first
// (R17) Protocol holds valid only with valid byte
// (R18) Byte moves when request, valid, accept high
// (R19) Accept high means byte taken for sending
// (R20) Protocol raises high-speed only with escape low
// (R21) Pattern 0100 maps to unknown-4 trigger
// (R22) Force-stop synchronised before state logic uses it; the raw input still gates take_byte in ST_WAIT
`timescale 1ns/10ps
module escape_lane_tx (
   input  wire logic          clock,
   input  wire logic          arst_n,
   escape_lane_if.device_end  ppi,
   output      logic          lane_dp,
   output      logic          lane_dn,
   output      logic          hs_active
);
   import escape_lane_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Decoding

   function automatic logic select_ok(input logic lpdt, input logic ulps,
                                      input logic [3:0] trig);
      logic [2:0] n;
      n = 3'(lpdt) + 3'(ulps) + 3'(trig[0]) + 3'(trig[1]) + 3'(trig[2]) + 3'(trig[3]);
      return n == 3'h1;
   endfunction : select_ok

   function automatic logic [7:0] trig_cmd(input logic [3:0] trig);
      logic [7:0] c;
      c = CMD_RESET;
      unique case (trig)
         TRIG_RESET: c = CMD_RESET;  // R15
         TRIG_UNK3:  c = CMD_UNK3;   // R15
         TRIG_UNK4:  c = CMD_UNK4;   // R21
         TRIG_UNK5:  c = CMD_UNK5;   // R15
         default:    c = CMD_RESET;
      endcase
      return c;
   endfunction : trig_cmd

   ////////////////////////////////////////////////////////////////////////////
   // Force-stop synchroniser

   logic force_meta_reg;
   logic force_sync_reg;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         force_meta_reg <= 1'b0;
         force_sync_reg <= 1'b0;
      end else begin
         force_meta_reg <= ppi.force_stop_request;
         force_sync_reg <= force_meta_reg;  // R22
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State

   state_t     state_reg,  state_next;
   mode_t      mode_reg,   mode_next;
   logic [2:0] cnt_reg,    cnt_next;
   logic       phase_reg,  phase_next;
   logic [7:0] shift_reg,  shift_next;
   logic [1:0] lp_reg,     lp_next;

   wire        esc        = ppi.escape_tx_request;
   wire        hs_req     = ppi.hs_tx_request;
   wire        sel_valid  = select_ok(ppi.lp_data_tx_select, ppi.ulp_entry_select,
                                      ppi.trigger_select);
   wire        bit_end    = phase_reg && (cnt_reg == BIT_LAST);
   // Raw force acts at once; the synchronised copy bridges until the state sits in Stop
   // A force shorter than two clocks can leave a one-cycle gap in that bridge
   wire        force_any  = ppi.force_stop_request || force_sync_reg;  // R01
   wire        accept     = (state_reg == ST_WAIT) && esc && !force_any;
   wire        take_byte  = accept && ppi.escape_tx_valid;  // R18
   wire        serial_bit = shift_reg[0];

   always_comb begin
      state_next = state_reg;
      mode_next  = mode_reg;
      cnt_next   = cnt_reg;
      phase_next = phase_reg;
      shift_next = shift_reg;
      unique case (state_reg)
         ST_STOP: begin
            cnt_next   = 3'h0;
            phase_next = 1'b0;
            if (hs_req) begin
               state_next = ST_HS;  // R06
            end else if (esc && sel_valid) begin
               state_next = ST_ENTRY;  // R03
               if (ppi.lp_data_tx_select) begin
                  mode_next  = MODE_LPDT;  // R07
                  shift_next = CMD_LPDT;
               end else if (ppi.ulp_entry_select) begin
                  mode_next  = MODE_ULPS;  // R09
                  shift_next = CMD_ULPS;
               end else begin
                  mode_next  = MODE_TRIG;  // R13
                  shift_next = trig_cmd(ppi.trigger_select);
               end
            end
         end
         ST_ENTRY: begin
            cnt_next = cnt_reg + 3'h1;  // R02
            if (cnt_reg == ENTRY_LAST) begin
               state_next = ST_CMD;
               cnt_next   = 3'h0;
            end
         end
         ST_CMD, ST_BITS: begin
            phase_next = !phase_reg;  // R02
            if (phase_reg) begin
               cnt_next   = cnt_reg + 3'h1;
               shift_next = {1'b0, shift_reg[7:1]};  // R16
            end
            if (bit_end) begin
               cnt_next = 3'h0;
               unique case (mode_reg)
                  MODE_LPDT: state_next = ST_WAIT;
                  MODE_ULPS: state_next = ST_ULPS;
                  MODE_TRIG: state_next = ST_TRIG;
                  default:   state_next = ST_MARK1;
               endcase
            end
         end
         ST_WAIT: begin
            if (!esc) begin
               state_next = ST_MARK1;  // R04
            end else if (take_byte) begin
               state_next = ST_BITS;  // R19
               shift_next = ppi.escape_tx_byte;
               phase_next = 1'b0;
            end
         end
         ST_ULPS: begin
            if (!esc || ppi.ulp_exit_request) begin
               state_next = ST_MARK1;  // R11
            end
         end
         ST_TRIG: begin
            if (!esc) begin
               state_next = ST_MARK1;  // R13
            end
         end
         ST_MARK1: begin
            if (!esc) begin
               state_next = ST_STOP;  // R11
            end
         end
         ST_HS: begin
            if (!hs_req) begin
               state_next = ST_STOP;
            end
         end
         default: state_next = ST_STOP;
      endcase
      if (force_sync_reg) begin
         state_next = ST_STOP;  // R01
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line levels, one phase per clock

   always_comb begin
      lp_next = LP_STOP;
      unique case (state_reg)
         ST_STOP, ST_HS: lp_next = (state_next == ST_HS) ? LP_SPACE : LP_STOP;
         ST_ENTRY: begin
            unique case (cnt_reg)
               3'h0:    lp_next = LP_DP_HI;
               3'h2:    lp_next = LP_DN_HI;
               default: lp_next = LP_SPACE;
            endcase
         end
         ST_CMD, ST_BITS: begin
            if (phase_reg) begin
               lp_next = LP_SPACE;
            end else begin
               lp_next = serial_bit ? LP_DP_HI : LP_DN_HI;  // R16
            end
         end
         ST_WAIT, ST_ULPS, ST_TRIG: lp_next = LP_SPACE;  // R12
         ST_MARK1: lp_next = LP_DP_HI;  // R11
         default: lp_next = LP_STOP;
      endcase
      if (force_sync_reg) begin
         lp_next = LP_STOP;  // R01
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_STOP;
         mode_reg  <= MODE_LPDT;
         cnt_reg   <= 3'h0;
         phase_reg <= 1'b0;
         shift_reg <= 8'h00;
         lp_reg    <= LP_STOP;
      end else begin
         state_reg <= state_next;
         mode_reg  <= mode_next;
         cnt_reg   <= cnt_next;
         phase_reg <= phase_next;
         shift_reg <= shift_next;
         lp_reg    <= lp_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs; the raw force input overrides the lines with no clock delay

   assign lane_dp              = force_any | lp_reg[1];  // R01
   assign lane_dn              = force_any | lp_reg[0];  // R01
   assign hs_active            = (state_reg == ST_HS) && !force_any;
   assign ppi.escape_tx_accept = accept;  // R19
   assign ppi.lane_stop        = force_any || (state_reg == ST_STOP);

endmodule : escape_lane_tx

// ### core/escape_lane_pkg.sv
package escape_lane_pkg;

   localparam int          BYTE_W       = 8;
   localparam int          TRIG_W       = 4;

   // Lane line levels, {dp, dn}
   localparam logic [1:0]  LP_STOP      = 2'h3;
   localparam logic [1:0]  LP_DP_HI     = 2'h2;
   localparam logic [1:0]  LP_DN_HI     = 2'h1;
   localparam logic [1:0]  LP_SPACE     = 2'h0;

   localparam logic [2:0]  ENTRY_LAST   = 3'h3;
   localparam logic [2:0]  BIT_LAST     = 3'h7;

   // Trigger select patterns
   localparam logic [3:0]  TRIG_RESET   = 4'h1;
   localparam logic [3:0]  TRIG_UNK3    = 4'h2;
   localparam logic [3:0]  TRIG_UNK4    = 4'h4;
   localparam logic [3:0]  TRIG_UNK5    = 4'h8;

   // Entry commands, bit 0 goes out first
   localparam logic [7:0]  CMD_LPDT     = 8'h87;
   localparam logic [7:0]  CMD_ULPS     = 8'h78;
   localparam logic [7:0]  CMD_RESET    = 8'h46;
   localparam logic [7:0]  CMD_UNK3     = 8'hba;
   localparam logic [7:0]  CMD_UNK4     = 8'h84;
   localparam logic [7:0]  CMD_UNK5     = 8'h05;

   // Controller register map, byte addresses
   localparam logic [3:0]  REG_CTRL     = 4'h0;
   localparam logic [3:0]  REG_TXDATA   = 4'h4;
   localparam logic [3:0]  REG_STATUS   = 4'h8;

   localparam int          CTRL_ESC     = 0;
   localparam int          CTRL_LPDT    = 1;
   localparam int          CTRL_ULPS    = 2;
   localparam int          CTRL_EXIT    = 3;
   localparam int          CTRL_TRIG_LO = 4;
   localparam int          CTRL_HS      = 8;
   localparam int          CTRL_FORCE   = 9;
   localparam int          CTRL_W       = 10;
   localparam logic [9:0]  CTRL_RESET   = 10'h000;

   localparam int          STAT_PEND    = 0;
   localparam int          STAT_STOP    = 1;
   localparam int          STAT_ESC     = 2;

   typedef enum logic [3:0] {
      ST_STOP  = 4'h0,
      ST_ENTRY = 4'h1,
      ST_CMD   = 4'h3,
      ST_WAIT  = 4'h2,
      ST_BITS  = 4'h6,
      ST_ULPS  = 4'h7,
      ST_TRIG  = 4'h5,
      ST_MARK1 = 4'h4,
      ST_HS    = 4'hc
   } state_t;

   typedef enum logic [1:0] {
      MODE_LPDT = 2'h0,
      MODE_ULPS = 2'h1,
      MODE_TRIG = 2'h2
   } mode_t;

endpackage : escape_lane_pkg

// ### core/escape_lane_if.sv
`timescale 1ns/10ps
interface escape_lane_if;
   logic       force_stop_request;
   logic       hs_tx_request;
   logic       escape_tx_request;
   logic       lp_data_tx_select;
   logic       ulp_entry_select;
   logic       ulp_exit_request;
   logic [3:0] trigger_select;
   logic [7:0] escape_tx_byte;
   logic       escape_tx_valid;
   logic       escape_tx_accept;
   logic       lane_stop;

   modport device_end (
      input  force_stop_request, hs_tx_request, escape_tx_request, lp_data_tx_select,
      input  ulp_entry_select, ulp_exit_request, trigger_select, escape_tx_byte,
      input  escape_tx_valid,
      output escape_tx_accept, lane_stop
   );

   modport protocol_end (
      output force_stop_request, hs_tx_request, escape_tx_request, lp_data_tx_select,
      output ulp_entry_select, ulp_exit_request, trigger_select, escape_tx_byte,
      output escape_tx_valid,
      input  escape_tx_accept, lane_stop
   );
endinterface : escape_lane_if

// ### core/escape_lane_ctrl.sv
`timescale 1ns/10ps
module escape_lane_ctrl (
   input  wire logic          clock,
   input  wire logic          arst_n,
   input  wire logic [3:0]    avs_address,
   input  wire logic          avs_read,
   input  wire logic          avs_write,
   input  wire logic [31:0]   avs_writedata,
   output      logic [31:0]   avs_readdata,
   output      logic          avs_waitrequest,
   escape_lane_if.protocol_end ppi
);
   import escape_lane_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Control word sanitising, so illegal mixes never reach the lane

   function automatic logic [9:0] clean_ctrl(input logic [9:0] w);
      logic [9:0] c;
      c = w;
      if (w[CTRL_ESC] && w[CTRL_HS]) begin
         c[CTRL_ESC] = 1'b0;  // R05
         c[CTRL_HS]  = 1'b0;  // R20
      end
      if (w[CTRL_LPDT]) begin
         c[CTRL_ULPS] = 1'b0;  // R08
         c[CTRL_TRIG_LO +: TRIG_W] = 4'h0;
      end else if (w[CTRL_ULPS]) begin
         c[CTRL_TRIG_LO +: TRIG_W] = 4'h0;  // R10
      end else if ($countones(w[CTRL_TRIG_LO +: TRIG_W]) > 1) begin
         c[CTRL_TRIG_LO +: TRIG_W] = 4'h0;  // R14
      end
      return c;
   endfunction : clean_ctrl

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [9:0]  ctrl_reg;
   logic [7:0]  byte_reg;
   logic        pend_reg;
   logic        rd_done_reg;
   logic [31:0] rdata_reg;

   wire sel_ctrl   = avs_address == REG_CTRL;
   wire sel_data   = avs_address == REG_TXDATA;
   wire sel_stat   = avs_address == REG_STATUS;
   wire data_stall = avs_write && sel_data && pend_reg;
   wire wr_ctrl    = avs_write && sel_ctrl;
   wire wr_data    = avs_write && sel_data && !pend_reg;
   wire taken      = pend_reg && ppi.escape_tx_accept && ppi.escape_tx_request;  // R18
   wire rd_first   = avs_read && !rd_done_reg;

   wire [31:0] status_word = {29'h0, ppi.escape_tx_request, ppi.lane_stop, pend_reg};
   wire [31:0] read_mux    = sel_ctrl ? {22'h0, ctrl_reg} :
                             sel_stat ? status_word      :
                             sel_data ? {24'h0, byte_reg} : 32'h0;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg    <= CTRL_RESET;
         byte_reg    <= 8'h00;
         pend_reg    <= 1'b0;
         rd_done_reg <= 1'b0;
         rdata_reg   <= 32'h0;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= clean_ctrl(avs_writedata[CTRL_W-1:0]);
         end
         if (wr_data) begin
            byte_reg <= avs_writedata[BYTE_W-1:0];  // R17
         end
         pend_reg    <= wr_data || (pend_reg && !taken);  // R17
         rd_done_reg <= rd_first;
         if (rd_first) begin
            rdata_reg <= read_mux;
         end
      end
   end

   // Reads take one wait cycle; a byte write waits while the previous byte is not yet taken by the lane
   assign avs_waitrequest = rd_first || data_stall;
   assign avs_readdata    = rdata_reg;

   assign ppi.force_stop_request = ctrl_reg[CTRL_FORCE];
   assign ppi.hs_tx_request      = ctrl_reg[CTRL_HS];       // R20
   assign ppi.escape_tx_request  = ctrl_reg[CTRL_ESC];      // R05
   assign ppi.lp_data_tx_select  = ctrl_reg[CTRL_LPDT];     // R03
   assign ppi.ulp_entry_select   = ctrl_reg[CTRL_ULPS];
   assign ppi.ulp_exit_request   = ctrl_reg[CTRL_EXIT];
   assign ppi.trigger_select     = ctrl_reg[CTRL_TRIG_LO +: TRIG_W];
   assign ppi.escape_tx_byte     = byte_reg;
   assign ppi.escape_tx_valid    = pend_reg;                // R17

endmodule : escape_lane_ctrl

// ### verif/escape_lane_sva.sv
`timescale 1ns/10ps
module escape_lane_sva (
   input wire logic       clock,
   input wire logic       arst_n,
   input wire logic       force_stop_request,
   input wire logic       escape_tx_request,
   input wire logic       lp_data_tx_select,
   input wire logic       ulp_entry_select,
   input wire logic [3:0] trigger_select,
   input wire logic [7:0] escape_tx_byte,
   input wire logic       escape_tx_valid,
   input wire logic       escape_tx_accept,
   input wire logic       lane_stop,
   input wire logic       lane_dp,
   input wire logic       lane_dn,
   input wire logic       hs_active
);
   import escape_lane_pkg::*;
   wire  [1:0] lines = {lane_dp, lane_dn};
   logic [7:0] taken_reg;
   // Keeps the taken byte, the input may be rewritten while it is shifted out
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) taken_reg <= 8'h00;
      else if (escape_tx_accept && escape_tx_valid) taken_reg <= escape_tx_byte;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////////////
   force_stop_a: assert property (
      force_stop_request |-> lines == LP_STOP && lane_stop && !escape_tx_accept)
      else $error("force-stop did not hold the lane in stop");
   accept_cause_a: assert property (
      escape_tx_accept |-> escape_tx_request && !force_stop_request)
      else $error("accept without request");
   byte_gap_a: assert property (
      escape_tx_accept && escape_tx_valid |=> (!escape_tx_accept) [*8])
      else $error("accept returned while a byte is shifted");
   first_bits_a: assert property (disable iff (!arst_n || force_stop_request)
      escape_tx_accept && escape_tx_valid |=> ##1 lines == (taken_reg[0] ? LP_DP_HI : LP_DN_HI)
      ##1 lines == LP_SPACE ##1 lines == (taken_reg[1] ? LP_DP_HI : LP_DN_HI))
      else $error("byte not sent low bit first");
   stop_idle_a: assert property (
      lane_stop && $past(lane_stop) |-> lines == LP_STOP)
      else $error("stop state without stop lines");
   entry_a: assert property (disable iff (!arst_n || force_stop_request)
      $fell(lane_stop) && !hs_active |-> $past(escape_tx_request)
      && $onehot({$past(lp_data_tx_select), $past(ulp_entry_select), $past(trigger_select)})
      ##1 lines == LP_DP_HI ##1 lines == LP_SPACE ##1 lines == LP_DN_HI ##1 lines == LP_SPACE)
      else $error("bad escape entry");
   hold_a: assert property (disable iff (!arst_n || force_stop_request)
      !lane_stop && !hs_active && escape_tx_request |=> !lane_stop)
      else $error("escape left while request high");
   mark1_a: assert property (disable iff (!arst_n || force_stop_request)
      $rose(lane_stop) && !$past(hs_active) |-> lines == LP_DP_HI ##1 lines == LP_STOP)
      else $error("no mark-1 before stop");
endmodule : escape_lane_sva

// ### verif/escape_mode_tx_lane_tb.sv
`timescale 1ns/10ps
module escape_mode_tx_lane_tb;
   import escape_lane_pkg::*;
   logic        clock = 1'b0;
   logic        arst_n = 1'b0;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd;
   logic        avs_waitrequest, lane_dp, lane_dn, hs_active, hs_active_2;
   logic [7:0]  b [3];
   logic        sym [$];
   integer      seed = 32'hf9ae57ee;
   int          err_count = 0;
   int          total_checks = 0;
   int          cycles = 0;
   escape_lane_if lane_if ();
   escape_lane_if bad_if ();
   always #20 clock = ~clock;
   escape_lane_tx u_escape_lane_tx (.clock(clock), .arst_n(arst_n), .ppi(lane_if),
      .lane_dp(lane_dp), .lane_dn(lane_dn), .hs_active(hs_active));
   escape_lane_tx u_escape_lane_tx_2 (.clock(clock), .arst_n(arst_n), .ppi(bad_if),
      .lane_dp(), .lane_dn(), .hs_active(hs_active_2));
   escape_lane_ctrl u_escape_lane_ctrl (.clock(clock), .arst_n(arst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ppi(lane_if));
   escape_lane_sva u_escape_lane_sva (.clock(clock), .arst_n(arst_n),
      .force_stop_request(lane_if.force_stop_request),
      .escape_tx_request(lane_if.escape_tx_request),
      .lp_data_tx_select(lane_if.lp_data_tx_select),
      .ulp_entry_select(lane_if.ulp_entry_select), .trigger_select(lane_if.trigger_select),
      .escape_tx_byte(lane_if.escape_tx_byte), .escape_tx_valid(lane_if.escape_tx_valid),
      .escape_tx_accept(lane_if.escape_tx_accept), .lane_stop(lane_if.lane_stop),
      .lane_dp(lane_dp), .lane_dn(lane_dn), .hs_active(hs_active));
   ////////////////////////////////////////////////////////////////////////////////
   // Line symbols since the last stop: 1 for LP-10, 0 for LP-01
   always @(negedge clock) begin
      if (lane_dp && lane_dn) sym.delete();
      else if (lane_dp != lane_dn) sym.push_back(lane_dp);
   end
   function automatic logic [7:0] sym_byte(input int off);
      logic [7:0] v;
      for (int i = 0; i < 8; i++) v[i] = sym[off + i];
      return v;
   endfunction : sym_byte
   function automatic logic [7:0] trig_cmd(input logic [3:0] t);
      case (t)
         TRIG_RESET: return CMD_RESET;
         TRIG_UNK3:  return CMD_UNK3;
         TRIG_UNK4:  return CMD_UNK4;
         default:    return CMD_UNK5;
      endcase
   endfunction : trig_cmd
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   ////////////////////////////////////////////////////////////////////////////////
   // Called just after a rising edge; waitrequest is looked at where it is settled
   task automatic av_access(input logic wr, input logic [3:0] a, input logic [31:0] d,
                            output logic [31:0] q);
      logic ws;
      avs_address <= a;
      avs_writedata <= d;
      if (wr) avs_write <= 1'b1;
      else avs_read <= 1'b1;
      do begin
         @(negedge clock);
         ws = avs_waitrequest;
         q = avs_readdata;
         @(posedge clock);
      end while (ws);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask : av_access
   task automatic ctrl_wait(input logic [31:0] d, input int n);
      av_access(1'b1, REG_CTRL, d, rd);
      repeat (n) @(posedge clock);
   endtask : ctrl_wait
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : wrap_up
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {bad_if.force_stop_request, bad_if.hs_tx_request, bad_if.escape_tx_request} = 3'h0;
      {bad_if.lp_data_tx_select, bad_if.ulp_entry_select, bad_if.ulp_exit_request} = 3'h0;
      {bad_if.trigger_select, bad_if.escape_tx_byte, bad_if.escape_tx_valid} = 13'h0;
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      av_access(1'b0, REG_CTRL, 32'h0, rd);
      chk("ctrl reset", 32'h0, rd);
      av_access(1'b0, REG_STATUS, 32'h0, rd);
      chk("status reset", 32'h2, rd);
      av_access(1'b1, 4'hc, 32'hffffffff, rd);
      av_access(1'b0, 4'hc, 32'h0, rd);
      chk("unmapped read", 32'h0, rd);
      // Control words that break the protocol rules are cleaned on write
      av_access(1'b1, REG_CTRL, 32'h103, rd);
      av_access(1'b0, REG_CTRL, 32'h0, rd);
      chk("escape with hs", 32'h2, rd);
      av_access(1'b1, REG_CTRL, 32'h76, rd);
      av_access(1'b0, REG_CTRL, 32'h0, rd);
      chk("data select alone", 32'h2, rd);
      av_access(1'b1, REG_CTRL, 32'hf4, rd);
      av_access(1'b0, REG_CTRL, 32'h0, rd);
      chk("ulp select alone", 32'h4, rd);
      av_access(1'b1, REG_CTRL, 32'h31, rd);
      av_access(1'b0, REG_CTRL, 32'h0, rd);
      chk("two triggers", 32'h1, rd);
      ctrl_wait(32'h8, 4);
      chk("exit ignored", 32'h1, lane_if.lane_stop);
      // Second and third bytes are queued while the lane is busy
      for (int i = 0; i < 3; i++) b[i] = 8'($random(seed));
      av_access(1'b1, REG_TXDATA, {24'h0, b[0]}, rd);
      av_access(1'b1, REG_CTRL, 32'h3, rd);
      av_access(1'b1, REG_TXDATA, {24'h0, b[1]}, rd);
      av_access(1'b1, REG_TXDATA, {24'h0, b[2]}, rd);
      do av_access(1'b0, REG_STATUS, 32'h0, rd); while (rd[0] === 1'b1);
      repeat (20) @(posedge clock);
      chk("lpdt command", CMD_LPDT, sym_byte(2));
      for (int i = 0; i < 3; i++) chk("lpdt byte", b[i], sym_byte(10 + 8 * i));
      ctrl_wait(32'h0, 4);
      chk("stop after lpdt", 32'h1, lane_if.lane_stop);
      for (int i = 0; i < 4; i++) begin
         ctrl_wait(32'h1 | (32'h10 << i), 24);
         chk("trigger command", trig_cmd(4'h1 << i), sym_byte(2));
         ctrl_wait(32'h0, 3);
         chk("stop after trigger", 32'h1, lane_if.lane_stop);
      end
      ctrl_wait(32'h5, 24);
      chk("ulp command", CMD_ULPS, sym_byte(2));
      ctrl_wait(32'hd, 3);
      chk("mark-1 lines", LP_DP_HI, {lane_dp, lane_dn});
      ctrl_wait(32'h0, 3);
      chk("stop after ulp", 32'h1, lane_if.lane_stop);
      // Force arrives while the lane waits for data
      ctrl_wait(32'h3, 24);
      ctrl_wait(32'h203, 0);
      chk("forced lines", LP_STOP, {lane_dp, lane_dn});
      ctrl_wait(32'h0, 4);
      ctrl_wait(32'h100, 3);
      chk("hs active", 32'h1, hs_active);
      ctrl_wait(32'h0, 3);
      // Second lane is driven against the protocol rules on purpose
      bad_if.escape_tx_request <= 1'b1;
      bad_if.lp_data_tx_select <= 1'b1;
      bad_if.ulp_entry_select <= 1'b1;
      repeat (4) @(posedge clock);
      chk("two selects refused", 32'h1, bad_if.lane_stop);
      bad_if.ulp_entry_select <= 1'b0;
      bad_if.hs_tx_request <= 1'b1;
      repeat (3) @(posedge clock);
      chk("high-speed wins", 32'h1, hs_active_2);
      wrap_up();
   end
endmodule : escape_mode_tx_lane_tb
